//--- dscg_top.sv
// port clock gating registers with AXI4-Lite slave and bus fault check
`timescale 1ns/10ps
// Summary of operation
// - Bits 7 to 0 each clock one port, bit 0 port A up to bit 7 port H, and a one lets the port run.
// - A zero bit stops that port's clock and keeps the port disabled.
// - A port access while its clock is off is answered with a bus fault.
// - Every gating bit is zero after reset, so all ports start unclocked.
// - Bits 31 to 8 are read-only zero and software keeps them on read-modify-write.
// - Run, sleep and deep-sleep gating are separate registers and this one acts only in deep-sleep.
// - The sleep and deep-sleep sets apply only while the auto gating select bit is set.
// - The deep-sleep gating register sits at offset 0x128 from base 0x400F.E000.
module dscg_top
   import dscg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [31:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic SLEEP_MODE,
   input wire logic DEEP_SLEEP_MODE,
   input wire logic PORT_ACC_VALID,
   input wire logic [2:0] PORT_ACC_SEL,
   output logic [7:0] PORT_CLK_EN,
   output logic PORT_ACC_FAULT
);
   dscg_gate_if gif ();

   // address match against one register of the block
   function automatic logic hit(input logic [31:0] addr, input logic [11:0] off);
      hit = (addr == (DSCG_BASE + {20'h00000, off}));
   endfunction

   // response for an address: unmapped words get a decode error
   function automatic logic [1:0] resp_for(input logic [31:0] addr);
      resp_for = (hit(addr, OFF_RUN_CLK_CFG) || hit(addr, OFF_RUN_GATE) || hit(addr, OFF_SLEEP_GATE)
         || hit(addr, OFF_DEEP_GATE)) ? RESP_OKAY : RESP_DECERR;
   endfunction

   logic [7:0] run_gate_r, run_gate_nxt;
   logic [7:0] sleep_gate_r, sleep_gate_nxt;
   logic [7:0] deep_sleep_port_clock_gate_r, deep_nxt;
   logic auto_sleep_gating_select_r, auto_nxt;
   logic aw_hold_r, aw_hold_nxt;
   logic [31:0] aw_addr_r;
   logic w_hold_r, w_hold_nxt;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, arready_nxt;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] port_clk_en_r;
   logic port_acc_fault_r;

   // handshake decode
   wire aw_take = AWVALID && awready_r;
   wire w_take = WVALID && wready_r;
   wire ar_take = ARVALID && arready_r;
   wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
   wire gate_lane = do_write && w_strb_r[GATE_LANE];
   wire auto_lane = do_write && w_strb_r[AUTO_SEL_LANE];
   wire [7:0] wr_gate = w_data_r[GATE_LSB +: NUM_PORTS];

   wire wr_deep = gate_lane && hit(aw_addr_r, OFF_DEEP_GATE);
   wire wr_run = gate_lane && hit(aw_addr_r, OFF_RUN_GATE);
   wire wr_sleep = gate_lane && hit(aw_addr_r, OFF_SLEEP_GATE);
   wire wr_cfg = auto_lane && hit(aw_addr_r, OFF_RUN_CLK_CFG);

   // next register values; a write whose lane is off leaves the field alone
   assign deep_nxt = wr_deep ? wr_gate : deep_sleep_port_clock_gate_r;
   assign run_gate_nxt = wr_run ? wr_gate : run_gate_r;
   assign sleep_gate_nxt = wr_sleep ? wr_gate : sleep_gate_r;
   assign auto_nxt = wr_cfg ? w_data_r[AUTO_SEL_POS] : auto_sleep_gating_select_r;

   // channel holds: address and data are taken in either order
   assign aw_hold_nxt = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_hold_r);
   assign w_hold_nxt = w_take ? 1'b1 : (do_write ? 1'b0 : w_hold_r);
   // read address is free whenever no answer is left standing, so it opens at once out of reset
   assign arready_nxt = ar_take ? 1'b0 : (!rvalid_r || RREADY);

   wire [31:0] rd_word =
      hit(ARADDR, OFF_DEEP_GATE) ? {24'h000000, deep_sleep_port_clock_gate_r} :
      hit(ARADDR, OFF_RUN_GATE) ? {24'h000000, run_gate_r} :
      hit(ARADDR, OFF_SLEEP_GATE) ? {24'h000000, sleep_gate_r} :
      hit(ARADDR, OFF_RUN_CLK_CFG) ? (WORD_ZERO | (32'h1 << AUTO_SEL_POS)) & {32{auto_sleep_gating_select_r}} :
      WORD_ZERO;

   // power mode; deep-sleep wins if both levels are up
   assign gif.mode = DEEP_SLEEP_MODE ? MODE_DEEP : (SLEEP_MODE ? MODE_SLEEP : MODE_RUN);
   assign gif.run_gate = run_gate_r;
   assign gif.sleep_gate = sleep_gate_r;
   assign gif.deep_gate = deep_sleep_port_clock_gate_r;
   assign gif.auto_sel = auto_sleep_gating_select_r;

   dscg_gate_sel u_sel (
      .gif (gif.sel)
   );

   wire fault_nxt = PORT_ACC_VALID && !port_clk_en_r[PORT_ACC_SEL];

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         run_gate_r <= GATE_RESET;
         sleep_gate_r <= GATE_RESET;
         deep_sleep_port_clock_gate_r <= GATE_RESET;
         auto_sleep_gating_select_r <= AUTO_SEL_RESET;
         port_clk_en_r <= GATE_RESET;
         port_acc_fault_r <= 1'b0;
      end
      else
      begin
         run_gate_r <= run_gate_nxt;
         sleep_gate_r <= sleep_gate_nxt;
         deep_sleep_port_clock_gate_r <= deep_nxt;
         auto_sleep_gating_select_r <= auto_nxt;
         port_clk_en_r <= gif.port_en;
         port_acc_fault_r <= fault_nxt;
      end
   end

   // write channel; ready drops while a beat is held so payload never overwrites
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         aw_addr_r <= WORD_ZERO;
         w_data_r <= WORD_ZERO;
         w_strb_r <= 4'h0;
      end
      else
      begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready_r <= !aw_hold_nxt;
         wready_r <= !w_hold_nxt;
         if (aw_take)
            aw_addr_r <= AWADDR;
         if (w_take)
         begin
            w_data_r <= WDATA;
            w_strb_r <= WSTRB;
         end
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= resp_for(aw_addr_r);
         end
         else if (BREADY)
            bvalid_r <= 1'b0;
      end
   end

   // read channel; one read at a time, answered the cycle after address
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= WORD_ZERO;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         arready_r <= arready_nxt;
         if (ar_take)
         begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= resp_for(ARADDR);
         end
         else if (RREADY)
            rvalid_r <= 1'b0;
      end
   end

   assign AWREADY = awready_r;
   assign WREADY = wready_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign ARREADY = arready_r;
   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;
   assign PORT_CLK_EN = port_clk_en_r;
   assign PORT_ACC_FAULT = port_acc_fault_r;

   // checks on the gating behaviour and the register bus
   // gates clear
   a_reset_gates_clear: assert property (@(posedge CLK) RST |=> (PORT_CLK_EN == 8'h00)
      && (deep_sleep_port_clock_gate_r == 8'h00))
      else $error("gates not clear after reset");

   a_fault_when_gated: assert property (@(posedge CLK) disable iff (RST)
      (PORT_ACC_VALID && !PORT_CLK_EN[PORT_ACC_SEL]) |=> PORT_ACC_FAULT)
      else $error("gated port access gave no fault");

   a_no_fault_clocked: assert property (@(posedge CLK) disable iff (RST)
      (PORT_ACC_VALID && PORT_CLK_EN[PORT_ACC_SEL]) |=> !PORT_ACC_FAULT)
      else $error("clocked port access faulted");

   a_deep_set_used: assert property (@(posedge CLK) disable iff (RST)
      (DEEP_SLEEP_MODE && auto_sleep_gating_select_r)
      |=> (PORT_CLK_EN == $past(deep_sleep_port_clock_gate_r)))
      else $error("deep-sleep set not applied");

   a_sleep_set_used: assert property (@(posedge CLK) disable iff (RST)
      (SLEEP_MODE && !DEEP_SLEEP_MODE && auto_sleep_gating_select_r)
      |=> (PORT_CLK_EN == $past(sleep_gate_r)))
      else $error("sleep set not applied");

   a_run_set_no_auto: assert property (@(posedge CLK) disable iff (RST)
      !auto_sleep_gating_select_r |=> (PORT_CLK_EN == $past(run_gate_r)))
      else $error("run set not applied without auto select");

   a_deep_write_decode: assert property (@(posedge CLK) disable iff (RST)
      (do_write && w_strb_r[GATE_LANE] && (aw_addr_r == 32'h400F_E128))
      |=> (deep_sleep_port_clock_gate_r == $past(wr_gate)) ##[0:2] BVALID)
      else $error("deep gate write at its offset lost");

   a_reserved_read_zero: assert property (@(posedge CLK) disable iff (RST)
      (ar_take && (ARADDR == 32'h400F_E128)) |=> (RVALID && (RDATA[31:8] == 24'h000000) && (RRESP == 2'h0)))
      else $error("reserved bits read nonzero");

   a_ready_after_reset: assert property (@(posedge CLK) RST
      |=> (!AWREADY && !WREADY && !ARREADY && !BVALID && !RVALID && !PORT_ACC_FAULT))
      else $error("bus or fault active after reset");

   a_unmapped_refused: assert property (@(posedge CLK) disable iff (RST)
      (ar_take && (ARADDR == 32'h400F_E12C)) |=> ((RRESP == RESP_DECERR) && (RDATA == WORD_ZERO)))
      else $error("unmapped read not refused");

   a_read_busy: assert property (@(posedge CLK) disable iff (RST)
      RVALID |-> !ARREADY)
      else $error("read address taken while answer stands");

   a_fault_needs_access: assert property (@(posedge CLK) disable iff (RST)
      PORT_ACC_FAULT |-> $past(PORT_ACC_VALID))
      else $error("fault without a port access");

   a_all_gated_off: assert property (@(posedge CLK) disable iff (RST)
      (DEEP_SLEEP_MODE && auto_sleep_gating_select_r && (deep_sleep_port_clock_gate_r == 8'h00))
      |=> (PORT_CLK_EN == 8'h00))
      else $error("port clock left on with its gate clear");

   a_lane_off_keeps: assert property (@(posedge CLK) disable iff (RST)
      (do_write && !w_strb_r[GATE_LANE]) |=> $stable(deep_sleep_port_clock_gate_r))
      else $error("gate written with its byte lane off");

   a_run_mode_set: assert property (@(posedge CLK) disable iff (RST)
      (!SLEEP_MODE && !DEEP_SLEEP_MODE)
      |=> (PORT_CLK_EN == $past(run_gate_r)))
      else $error("run set not applied in run mode");

   a_auto_read_back: assert property (@(posedge CLK) disable iff (RST)
      (ar_take && (ARADDR == (DSCG_BASE + {20'h00000, OFF_RUN_CLK_CFG})))
      |=> (RDATA[AUTO_SEL_POS] == $past(auto_sleep_gating_select_r)))
      else $error("auto select bit not read back");
endmodule

//--- dscg_pkg.sv
// shared constants and types for the port clock gating block
package dscg_pkg;
   // register map: block base plus word offsets
   localparam logic [31:0] DSCG_BASE = 32'h400F_E000;
   localparam logic [11:0] OFF_RUN_CLK_CFG = 12'h060;
   localparam logic [11:0] OFF_RUN_GATE = 12'h108;
   localparam logic [11:0] OFF_SLEEP_GATE = 12'h118;
   localparam logic [11:0] OFF_DEEP_GATE = 12'h128;
   // field layout
   localparam int NUM_PORTS = 8;
   localparam int GATE_LSB = 0;
   localparam int GATE_LANE = 0;
   localparam int AUTO_SEL_POS = 25;
   localparam int AUTO_SEL_LANE = 3;
   // reset values
   localparam logic [7:0] GATE_RESET = 8'h00;
   localparam logic AUTO_SEL_RESET = 1'b0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // power mode the system is in
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP = 2'b10
   } dscg_mode_e;
endpackage

//--- dscg_gate_if.sv
// carrier between the register block and the gate selector
`timescale 1ns/10ps
interface dscg_gate_if;
   import dscg_pkg::*;
   logic [7:0] run_gate;
   logic [7:0] sleep_gate;
   logic [7:0] deep_gate;
   logic auto_sel;
   dscg_mode_e mode;
   logic [7:0] port_en;
   modport regs (output run_gate, output sleep_gate, output deep_gate, output auto_sel, output mode,
      input port_en);
   modport sel (input run_gate, input sleep_gate, input deep_gate, input auto_sel, input mode,
      output port_en);
endinterface

//--- dscg_gate_sel.sv
// picks the gating set that applies in the present power mode
`timescale 1ns/10ps
module dscg_gate_sel
   import dscg_pkg::*;
(
   dscg_gate_if.sel gif
);
   // choose set by mode; without auto select the run set rules every mode
   always_comb
   begin
      gif.port_en = gif.run_gate;
      unique case (gif.mode)
         MODE_RUN:
         begin
            gif.port_en = gif.run_gate;
         end
         MODE_SLEEP:
         begin
            gif.port_en = gif.auto_sel ? gif.sleep_gate : gif.run_gate;
         end
         MODE_DEEP:
         begin
            gif.port_en = gif.auto_sel ? gif.deep_gate : gif.run_gate;
         end
         default:
         begin
            gif.port_en = gif.run_gate;
         end
      endcase
   end
endmodule

//--- dscg_port_model.sv
// partner model of the gated port units, issuing port accesses
`timescale 1ns/10ps
module dscg_port_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic [2:0] req_sel,
   input wire logic fault,
   output logic acc_valid,
   output logic [2:0] acc_sel,
   output int fault_cnt
);
   // one access cycle per request; idle select toggles so no stale index is reused
   always_ff @(posedge clk)
   begin
      acc_valid <= req & ~rst;
      acc_sel <= rst ? 3'h0 : (req ? req_sel : ~acc_sel);
      fault_cnt <= rst ? 0 : fault_cnt + ((fault === 1'b1) ? 1 : 0);
   end
endmodule

//--- dscg_top_tb_top.sv
// self-checking bench for the port clock gating block
`timescale 1ns/10ps
module dscg_top_tb_top
   import dscg_pkg::*;
;
   logic CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic SLEEP_MODE = 1'b0, DEEP_SLEEP_MODE = 1'b0, req = 1'b0;
   logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, d;
   logic [3:0] WSTRB = 4'hF;
   logic [2:0] req_sel = 3'h0, PORT_ACC_SEL;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PORT_ACC_VALID, PORT_ACC_FAULT;
   logic [1:0] BRESP, RRESP;
   logic [7:0] PORT_CLK_EN;
   int mismatches = 0, checks = 0, fault_cnt;
   // free-running system clock
   always #5 CLK = ~CLK;
   dscg_top dut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
      .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
      .RREADY(RREADY), .SLEEP_MODE(SLEEP_MODE), .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE),
      .PORT_ACC_VALID(PORT_ACC_VALID), .PORT_ACC_SEL(PORT_ACC_SEL), .PORT_CLK_EN(PORT_CLK_EN),
      .PORT_ACC_FAULT(PORT_ACC_FAULT));
   dscg_port_model pm (.clk(CLK), .rst(RST), .req(req), .req_sel(req_sel), .fault(PORT_ACC_FAULT),
      .acc_valid(PORT_ACC_VALID), .acc_sel(PORT_ACC_SEL), .fault_cnt(fault_cnt));
   // verdict in one place; also reached from any exhausted wait
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // write: both channels offered together, each dropped once taken
   task automatic wr(input logic [11:0] off, input logic [31:0] v, input logic [1:0] er);
      int n;
      @(posedge CLK);
      AWADDR <= DSCG_BASE + {20'h0, off};
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge CLK);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
         if (BVALID === 1'b1) break;
      end
      BREADY <= 1'b0;
      if (n == 50)
      begin
         mismatches++;
         tally_and_finish;
      end
      else
         chk({30'h0, BRESP}, {30'h0, er});
   endtask
   // read: response code compared, data handed back
   task automatic rd(input logic [11:0] off, input logic [1:0] er);
      int n;
      @(posedge CLK);
      ARADDR <= DSCG_BASE + {20'h0, off};
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge CLK);
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
         if (RVALID === 1'b1) break;
      end
      RREADY <= 1'b0;
      d = RDATA;
      if (n == 50)
      begin
         mismatches++;
         tally_and_finish;
      end
      else
         chk({30'h0, RRESP}, {30'h0, er});
   endtask
   // mode change, then the registered enables settle
   task automatic mode(input logic s, input logic dp, input logic [7:0] en);
      @(posedge CLK);
      SLEEP_MODE <= s;
      DEEP_SLEEP_MODE <= dp;
      repeat (3) @(posedge CLK);
      chk({24'h0, PORT_CLK_EN}, {24'h0, en});
   endtask
   // one port access through the partner, counting faults it saw
   task automatic acc(input logic [2:0] s, input int inc);
      int b;
      b = fault_cnt;
      @(posedge CLK);
      req <= 1'b1;
      req_sel <= s;
      @(posedge CLK);
      req <= 1'b0;
      repeat (3) @(posedge CLK);
      chk(32'(fault_cnt - b), 32'(inc));
   endtask
   // reset state: no port clocked, the deep set and the auto select clear
   task automatic t_reset;
      chk({24'h0, PORT_CLK_EN}, 32'h0);
      rd(OFF_DEEP_GATE, RESP_OKAY);
      chk(d, 32'h0);
      rd(OFF_RUN_CLK_CFG, RESP_OKAY);
      chk(d, 32'h0);
      $display("reset test done");
   endtask
   // reserved bits written high must read back zero; unmapped place refused
   task automatic t_regs;
      wr(OFF_RUN_GATE, 32'h0000_000F, RESP_OKAY);
      wr(OFF_SLEEP_GATE, 32'h0000_0030, RESP_OKAY);
      wr(OFF_DEEP_GATE, 32'hFFFF_FFA5, RESP_OKAY);
      rd(OFF_DEEP_GATE, RESP_OKAY);
      chk(d, 32'h0000_00A5);
      // gate byte lane switched off: the deep set must keep its value
      WSTRB <= 4'hE;
      wr(OFF_DEEP_GATE, 32'h0000_005A, RESP_OKAY);
      WSTRB <= 4'hF;
      rd(OFF_DEEP_GATE, RESP_OKAY);
      chk(d, 32'h0000_00A5);
      rd(12'h12C, RESP_DECERR);
      chk(d, 32'h0);
      wr(12'h12C, 32'hFFFF_FFFF, RESP_DECERR);
      rd(OFF_RUN_GATE, RESP_OKAY);
      chk(d, 32'h0000_000F);
      $display("register test done");
   endtask
   task automatic t_modes;
      mode(1'b0, 1'b1, 8'h0F);
      wr(OFF_RUN_CLK_CFG, 32'h1 << AUTO_SEL_POS, RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk({24'h0, PORT_CLK_EN}, 32'h0000_00A5);
      rd(OFF_RUN_CLK_CFG, RESP_OKAY);
      chk(d, 32'h1 << AUTO_SEL_POS);
      mode(1'b1, 1'b0, 8'h30);
      // both mode levels up: deep-sleep wins
      mode(1'b1, 1'b1, 8'hA5);
      mode(1'b0, 1'b0, 8'h0F);
      $display("mode test done");
   endtask
   // deep set A5 applies: clear bits fault, set bits do not
   task automatic t_fault;
      mode(1'b0, 1'b1, 8'hA5);
      acc(3'h1, 1);
      acc(3'h0, 0);
      acc(3'h7, 0);
      acc(3'h6, 1);
      rd(OFF_DEEP_GATE, RESP_OKAY);
      wr(OFF_DEEP_GATE, d & 32'hFFFF_FF00, RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk({24'h0, PORT_CLK_EN}, 32'h0);
      acc(3'h0, 1);
      $display("fault test done");
   endtask
   // mid-run reset must clear a live gate set and the auto select
   task automatic t_rst;
      wr(OFF_DEEP_GATE, 32'h0000_00FF, RESP_OKAY);
      repeat (2) @(posedge CLK);
      chk({24'h0, PORT_CLK_EN}, 32'h0000_00FF);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
      t_reset;
      $display("mid-run reset test done");
   endtask
   // main sequence; the deep set is loaded before any port access, and accesses to gated ports must fault
   initial
   begin
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      t_reset;
      t_regs;
      t_modes;
      t_fault;
      t_rst;
      tally_and_finish;
   end
endmodule
